/* hdl/bus_area_config_map.svh */
// Offsets, field positions and reset values of the bus area configuration register.
// Assumes inclusion by bare name from the package and the design files.
`ifndef BUS_AREA_CONFIG_MAP_SVH
`define BUS_AREA_CONFIG_MAP_SVH

`define BAC_ADDR_CFG 12'h000
`define BAC_ADDR_STATUS 12'h004
`define BAC_ADDR_STANDBY 12'h008
`define BAC_RESET_VALUE 16'h0000
`define BAC_BIT_ADDR_PULLUP 15
`define BAC_BIT_DATA_PULLUP 14
`define BAC_BIT_MEMCTL_FLOAT 13
`define BAC_BIT_STROBE_FLOAT 12
`define BAC_BIT_BYTE_ORDER 11
`define BAC_A0_BURST_HI 10
`define BAC_A0_BURST_LO 9
`define BAC_A5_BURST_HI 8
`define BAC_A5_BURST_LO 7
`define BAC_A6_BURST_HI 6
`define BAC_A6_BURST_LO 5
`define BAC_MEM_TYPE_HI 4
`define BAC_MEM_TYPE_LO 2
`define BAC_BIT_AREA5_CARD 1
`define BAC_BIT_AREA6_CARD 0
`define BAC_WRITE_MASK 16'hF7FF
`define BAC_ADDR_PULLUP_CYCLES 3'h4
`define BAC_MEM_TYPE_ORDINARY 3'h0
`define BAC_MEM_TYPE_A3_SDRAM 3'h2
`define BAC_MEM_TYPE_BOTH_SDRAM 3'h3
`define BAC_BURST_LEN_4 5'h04
`define BAC_BURST_LEN_8 5'h08
`define BAC_BURST_LEN_16 5'h10
`define BAC_BURST_LEN_NONE 5'h00

`endif

/* hdl/bus_area_config_pkg.sv */
// Types shared by the bus area configuration block.
// Assumes the map header sits beside it on the include path.
`include "bus_area_config_map.svh"

package bus_area_config_pkg;

    typedef enum logic [1:0] {
        BURST_NONE,
        BURST_4,
        BURST_8,
        BURST_16
    } burst_code_t;

    typedef enum logic [1:0] {
        AREA23_ORDINARY,
        AREA3_SDRAM,
        AREA23_SDRAM,
        AREA23_INVALID
    } mem_kind_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic byte_order_seen;
    } cfg_state_t;

endpackage : bus_area_config_pkg

/* hdl/cfg_link_if.sv */
// Carrier between the register bank and the pin control logic.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
`default_nettype none

interface cfg_link_if;
    logic [15:0] cfg;
    logic standby;
    logic bus_released;
    logic bus_ack_rise;
    logic data_bus_busy;

    modport bank (output cfg, output standby, output bus_released, output bus_ack_rise, output data_bus_busy);
    modport pins (input cfg, input standby, input bus_released, input bus_ack_rise, input data_bus_busy);
endinterface : cfg_link_if

`default_nettype wire

/* hdl/pin_float_ctl.sv */
// Pull-up and float control of the external bus pins, driven from the configuration word.
// Assumes all inputs are already synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none

`include "bus_area_config_map.svh"

module pin_float_ctl
    import bus_area_config_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    cfg_link_if.pins link,
    output logic addr_pullup_q,
    output logic data_pullup_q,
    output logic memctl_drive_q,
    output logic memctl_high_q,
    output logic strobe_drive_q
);

    typedef struct packed {
        logic [2:0] cnt;
        logic addr_pu;
        logic data_pu;
        logic memctl_drive;
        logic memctl_high;
        logic strobe_drive;
    } pin_state_t;

    pin_state_t s_q;
    pin_state_t s_d;

    always_comb begin
        s_d = s_q;
        // The window opens on the acknowledge edge and counts exactly four cycles.
        if (link.bus_ack_rise && link.cfg[`BAC_BIT_ADDR_PULLUP]) begin
            s_d.cnt = `BAC_ADDR_PULLUP_CYCLES;
        end else if (s_q.cnt != 3'h0) begin
            s_d.cnt = s_q.cnt - 3'h1;
        end
        s_d.addr_pu = (s_d.cnt != 3'h0);
        s_d.data_pu = link.cfg[`BAC_BIT_DATA_PULLUP] && !link.data_bus_busy;
        if (link.standby) begin
            s_d.memctl_drive = link.cfg[`BAC_BIT_MEMCTL_FLOAT];
            s_d.memctl_high = link.cfg[`BAC_BIT_MEMCTL_FLOAT];
        end else begin
            s_d.memctl_drive = 1'b1;
            s_d.memctl_high = 1'b0;
        end
        if (link.standby || link.bus_released) begin
            s_d.strobe_drive = link.cfg[`BAC_BIT_STROBE_FLOAT];
        end else begin
            s_d.strobe_drive = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign addr_pullup_q = s_q.addr_pu;
    assign data_pullup_q = s_q.data_pu;
    assign memctl_drive_q = s_q.memctl_drive;
    assign memctl_high_q = s_q.memctl_high;
    assign strobe_drive_q = s_q.strobe_drive;

endmodule : pin_float_ctl

`default_nettype wire

/* hdl/bus_area_config_register.sv */
// Bus area configuration register with its APB slave and the decoded area settings.
// Assumes an APB master on pclk; mode, acknowledge and standby inputs come from pins
// or other clock domains and are synchronised here.
`timescale 1ns/100ps
`default_nettype none

`include "bus_area_config_map.svh"

// Functional notes
// - Sixteen bits, zero at power-on, except byte order.
// - Manual reset and standby keep contents.
// - Address pull-up four cycles after acknowledge.
// - Data pull-up while data bus idle.
// - Standby memory pins float or drive high.
// - Row/column strobes float or drive in standby/release.
// - Read-only byte order caught from mode pin.
// - Area 0 burst length select.
// - Area 5 burst length select.
// - Area 6 burst length select.
// - Areas 2/3 memory type select.
// - Area 5 card space select.
// - Area 6 card space select.
module bus_area_config_register
    import bus_area_config_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic byte_order_mode_pin,
    input wire logic manual_reset_req,
    input wire logic standby_req,
    input wire logic bus_released_in,
    input wire logic bus_ack_in,
    input wire logic data_bus_busy_in,
    output logic addr_pullup_en,
    output logic data_pullup_en,
    output logic memctl_drive,
    output logic memctl_high,
    output logic strobe_drive,
    output logic little_endian,
    output logic [4:0] area0_burst_len,
    output logic [4:0] area5_burst_len,
    output logic [4:0] area6_burst_len,
    output logic area2_sdram,
    output logic area3_sdram,
    output logic area5_card_sel,
    output logic area6_card_sel
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------

    function automatic logic [4:0] burst_len(input logic [1:0] code);
        case (burst_code_t'(code))
            BURST_4: burst_len = `BAC_BURST_LEN_4;
            BURST_8: burst_len = `BAC_BURST_LEN_8;
            BURST_16: burst_len = `BAC_BURST_LEN_16;
            default: burst_len = `BAC_BURST_LEN_NONE;
        endcase
    endfunction : burst_len

    function automatic mem_kind_t mem_kind(input logic [2:0] code);
        if (code == `BAC_MEM_TYPE_ORDINARY) begin
            mem_kind = AREA23_ORDINARY;
        end else if (code == `BAC_MEM_TYPE_A3_SDRAM) begin
            mem_kind = AREA3_SDRAM;
        end else if (code == `BAC_MEM_TYPE_BOTH_SDRAM) begin
            mem_kind = AREA23_SDRAM;
        end else begin
            mem_kind = AREA23_INVALID;
        end
    endfunction : mem_kind

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------

    // Bit order: mode pin, standby, release, acknowledge, data busy.
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic ack_last_q;
    logic strap_taken_q;
    // The manual reset request is only reported, but it still comes from a pin.
    logic [1:0] mrst_sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            ack_last_q <= 1'b0;
            mrst_sync_q <= 2'h0;
        end else begin
            sync1_q <= {byte_order_mode_pin, standby_req, bus_released_in, bus_ack_in, data_bus_busy_in};
            sync2_q <= sync1_q;
            ack_last_q <= sync2_q[1];
            mrst_sync_q <= {mrst_sync_q[0], manual_reset_req};
        end
    end

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------

    cfg_state_t st_q;
    cfg_state_t st_d;
    logic [1:0] strap_cnt_q;
    logic wr_hit;
    logic [15:0] wmask;

    // The strap is taken on the third edge after release, once the synchroniser holds a real pin value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_q <= 2'h0;
            strap_taken_q <= 1'b0;
        end else begin
            if (strap_cnt_q != 2'h3) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
            strap_taken_q <= (strap_cnt_q == 2'h2) || strap_taken_q;
        end
    end

    assign wr_hit = psel && penable && pwrite && (paddr == `BAC_ADDR_CFG);
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & `BAC_WRITE_MASK;

    always_comb begin
        st_d = st_q;
        // Manual reset and standby leave the word alone; only presetn clears it.
        if (!strap_taken_q && (strap_cnt_q == 2'h2)) begin
            st_d.cfg[`BAC_BIT_BYTE_ORDER] = sync2_q[4];
            st_d.byte_order_seen = 1'b1;
        end
        if (wr_hit) begin
            st_d.cfg = (st_d.cfg & ~wmask) | (pwdata[15:0] & wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.cfg <= `BAC_RESET_VALUE;
            st_q.byte_order_seen <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: zero wait states, unmapped addresses answer with an error.
    // ----------------------------------------------------------------

    logic [31:0] rd_mux;
    logic addr_ok;

    always_comb begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b1;
        if (paddr == `BAC_ADDR_CFG) begin
            rd_mux = {16'h0000, st_q.cfg};
        end else if (paddr == `BAC_ADDR_STATUS) begin
            rd_mux = {27'h0000000, st_q.byte_order_seen, sync2_q[0], sync2_q[3], sync2_q[2], mrst_sync_q[1]};
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (!addr_ok || (pwrite && (paddr != `BAC_ADDR_CFG)));
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoded area settings
    // ----------------------------------------------------------------

    mem_kind_t kind;
    assign kind = mem_kind(st_q.cfg[`BAC_MEM_TYPE_HI:`BAC_MEM_TYPE_LO]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            little_endian <= 1'b0;
            area0_burst_len <= `BAC_BURST_LEN_NONE;
            area5_burst_len <= `BAC_BURST_LEN_NONE;
            area6_burst_len <= `BAC_BURST_LEN_NONE;
            area2_sdram <= 1'b0;
            area3_sdram <= 1'b0;
            area5_card_sel <= 1'b0;
            area6_card_sel <= 1'b0;
        end else begin
            little_endian <= st_q.cfg[`BAC_BIT_BYTE_ORDER];
            area0_burst_len <= burst_len(st_q.cfg[`BAC_A0_BURST_HI:`BAC_A0_BURST_LO]);
            area5_burst_len <= burst_len(st_q.cfg[`BAC_A5_BURST_HI:`BAC_A5_BURST_LO]);
            area6_burst_len <= burst_len(st_q.cfg[`BAC_A6_BURST_HI:`BAC_A6_BURST_LO]);
            // Prohibited codes are treated as ordinary memory so a bad write cannot start SDRAM cycles.
            area2_sdram <= (kind == AREA23_SDRAM);
            area3_sdram <= (kind == AREA23_SDRAM) || (kind == AREA3_SDRAM);
            area5_card_sel <= st_q.cfg[`BAC_BIT_AREA5_CARD];
            area6_card_sel <= st_q.cfg[`BAC_BIT_AREA6_CARD];
        end
    end

    // ----------------------------------------------------------------
    // Pin control
    // ----------------------------------------------------------------

    cfg_link_if link ();

    assign link.cfg = st_q.cfg;
    assign link.standby = sync2_q[3];
    assign link.bus_released = sync2_q[2];
    assign link.bus_ack_rise = sync2_q[1] && !ack_last_q;
    assign link.data_bus_busy = sync2_q[0];

    pin_float_ctl u_pins (
        .pclk(pclk),
        .presetn(presetn),
        .link(link),
        .addr_pullup_q(addr_pullup_en),
        .data_pullup_q(data_pullup_en),
        .memctl_drive_q(memctl_drive),
        .memctl_high_q(memctl_high),
        .strobe_drive_q(strobe_drive)
    );

endmodule : bus_area_config_register

`default_nettype wire

/* tb/bus_area_config_properties.sv */
// Concurrent checks on the ports of the bus area configuration register.
// Assumes binding into bus_area_config_register; a shadow of the written word is kept here.
`timescale 1ns/100ps
`default_nettype none

module bac_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic standby_req,
    input wire logic bus_released_in,
    input wire logic bus_ack_in,
    input wire logic data_bus_busy_in,
    input wire logic addr_pullup_en,
    input wire logic data_pullup_en,
    input wire logic memctl_drive,
    input wire logic memctl_high,
    input wire logic strobe_drive,
    input wire logic little_endian,
    input wire logic [4:0] area0_burst_len,
    input wire logic [4:0] area5_burst_len,
    input wire logic [4:0] area6_burst_len,
    input wire logic area2_sdram,
    input wire logic area3_sdram,
    input wire logic area5_card_sel,
    input wire logic area6_card_sel
);
    // ----------------------------------------
    // Shadow of the configuration word
    // ----------------------------------------
    logic [15:0] sh_q;
    logic [2:0] age_q;
    wire wr = psel && penable && pwrite && pready && paddr == 12'h000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= 16'h0000;
            age_q <= 3'h0;
        end else begin
            if (wr && pstrb[0]) sh_q[7:0] <= pwdata[7:0];
            if (wr && pstrb[1]) sh_q[15:8] <= pwdata[15:8];
            if (age_q != 3'h7) age_q <= age_q + 3'h1;
        end
    end

    function automatic logic [4:0] blen(input logic [1:0] c);
        return (c == 2'h0) ? 5'h00 : 5'h02 << c;
    endfunction : blen

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The pull-up pulse is exactly four cycles wide and then drops.
    sequence pu_pulse_s;
        addr_pullup_en [*4] ##1 !addr_pullup_en;
    endsequence

    ready_one_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    unmapped_err_a: assert property (pready && paddr == 12'h008 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper half set");
    burst_dec_a: assert property (area0_burst_len == blen($past(sh_q[10:9])) && area5_burst_len ==
        blen($past(sh_q[8:7])) && area6_burst_len == blen($past(sh_q[6:5]))) else $error("burst decode");
    area_sel_a: assert property (area5_card_sel == $past(sh_q[1]) && area6_card_sel == $past(sh_q[0])
        && area3_sdram == ($past(sh_q[4:3]) == 2'b01) && area2_sdram == ($past(sh_q[4:2]) == 3'h3))
        else $error("area select decode");
    byte_hold_a: assert property (age_q == 3'h7 |-> $stable(little_endian)) else $error("byte order moved");
    data_pu_a: assert property (data_bus_busy_in [*4] |-> !data_pullup_en) else $error("pull-up while busy");
    memctl_run_a: assert property (!standby_req [*4] |-> memctl_drive && !memctl_high)
        else $error("memctl wrong outside standby");
    memctl_sb_a: assert property (standby_req [*4] |-> memctl_drive == memctl_high)
        else $error("memctl wrong in standby");
    strobe_run_a: assert property (!(standby_req || bus_released_in) [*4] |-> strobe_drive)
        else $error("strobe not driven");
    pu_len_a: assert property ($rose(addr_pullup_en) |-> pu_pulse_s) else $error("pull-up width");
    pu_cause_a: assert property ($rose(bus_ack_in) && sh_q[15] |-> ##[1:6] addr_pullup_en)
        else $error("no pull-up after acknowledge");
endmodule : bac_checker

bind bus_area_config_register bac_checker checker_i (.*);

`default_nettype wire

/* tb/ext_bus_model.sv */
// External bus side: bus master acknowledge, data bus use, standby and release levels.
// Assumes commands from the bench; levels change just after a clock edge.
`timescale 1ns/100ps
`default_nettype none

module ext_bus_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] cmd,
    output logic bus_ack_in,
    output logic data_bus_busy_in,
    output logic standby_req,
    output logic bus_released_in
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {bus_ack_in, data_bus_busy_in, standby_req, bus_released_in} <= 4'h0;
        end else begin
            {bus_ack_in, data_bus_busy_in, standby_req, bus_released_in} <= cmd;
        end
    end
endmodule : ext_bus_model

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the bus area configuration register.
// Assumes design, checker and bus model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t %h %h", $time, a, b); end end

module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic byte_order_mode_pin = 1'b1, manual_reset_req = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h3, cmd = 4'h0;
    logic bus_ack_in, data_bus_busy_in, standby_req, bus_released_in, addr_pullup_en, data_pullup_en;
    logic memctl_drive, memctl_high, strobe_drive, little_endian, area2_sdram, area3_sdram;
    logic area5_card_sel, area6_card_sel;
    logic [4:0] area0_burst_len, area5_burst_len, area6_burst_len;
    int mismatches = 0, tests_run = 0, cyc = 0;

    bus_area_config_register dut (.*);
    ext_bus_model bus_i (.*);

    always #10 pclk = ~pclk;

    // ----------------------------------------
    // Bus cycles and closing
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_rw();
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000_0800)
        `CHK(little_endian, 1'b1)
        apb(1'b1, 12'h000, 32'hFFFF_FFEF);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000_FFEF)
        apb(1'b1, 12'h000, 32'h0000_0000);
        pstrb <= 4'h1;
        apb(1'b1, 12'h000, 32'h0000_FFEF);
        pstrb <= 4'h3;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000_08EF)
    endtask : t_rw

    task automatic t_dec();
        logic [1:0] c;
        logic [4:0] e;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            apb(1'b1, 12'h000, {16'h0000, 5'h00, c, c, c, 1'b0, c[1], c[1] & c[0], c});
            repeat (2) @(posedge pclk);
            e = (c == 2'h0) ? 5'h00 : 5'h02 << c;
            `CHK({area0_burst_len, area5_burst_len, area6_burst_len}, {e, e, e})
            `CHK({area2_sdram, area3_sdram, area5_card_sel, area6_card_sel}, {c == 2'h3, c[1], c})
        end
    endtask : t_dec

    task automatic t_pins();
        logic [3:0] n;
        n = 4'h0;
        apb(1'b1, 12'h000, 32'h0000_F000);
        repeat (4) @(posedge pclk);
        `CHK(data_pullup_en, 1'b1)
        cmd <= 4'h4;
        repeat (5) @(posedge pclk);
        `CHK(data_pullup_en, 1'b0)
        cmd <= 4'h8;
        repeat (12) begin
            @(posedge pclk);
            n = n + {3'h0, addr_pullup_en};
        end
        `CHK(n, 4'h4)
        cmd <= 4'h2;
        repeat (5) @(posedge pclk);
        `CHK({memctl_drive, memctl_high, strobe_drive}, 3'b111)
        apb(1'b1, 12'h000, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK({memctl_drive, memctl_high, strobe_drive}, 3'b000)
        cmd <= 4'h1;
        repeat (5) @(posedge pclk);
        `CHK({memctl_drive, memctl_high, strobe_drive}, 3'b100)
        cmd <= 4'h0;
    endtask : t_pins

    task automatic t_keep();
        apb(1'b1, 12'h000, 32'h0000_A5AD);
        manual_reset_req <= 1'b1;
        cmd <= 4'h2;
        repeat (5) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000_ADAD)
        apb(1'b0, 12'h004, 32'h0);
        `CHK({er, rd}, {1'b0, 32'h0000_0015})
        manual_reset_req <= 1'b0;
        cmd <= 4'h0;
        byte_order_mode_pin <= 1'b0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(little_endian, 1'b0)
    endtask : t_keep

    task automatic t_err();
        apb(1'b0, 12'h008, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h004, 32'h0000_FFFF);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000_0000)
    endtask : t_err

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_rw();
        t_dec();
        t_pins();
        t_keep();
        t_err();
        test_done();
    end
endmodule : tb

`default_nettype wire
